// >>> tick_timer_pkg.sv
// Purpose: Constants and types for the clock tick timer block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Shared by the timer design and its checks.
`default_nettype none

package tick_timer_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int IDX_W  = 16;
  localparam int DATA_W = 32;
  localparam int IDX_LO = 2;

  // ==========================================================================
  // Register indices
  localparam logic [IDX_W-1:0] IRQ_PRIORITY_LEVELS_IDX = 16'hFF20;
  localparam logic [IDX_W-1:0] IRQ_ENABLE_BITS_IDX     = 16'hFF22;
  localparam logic [IDX_W-1:0] IRQ_FACTOR_FLAGS_IDX    = 16'hFF26;
  localparam logic [IDX_W-1:0] TICK_TIMER_CONTROL_IDX  = 16'hFF40;
  localparam logic [IDX_W-1:0] TICK_TIMER_COUNT_IDX    = 16'hFF41;
  localparam logic [IDX_W-1:0] EVENT_STATUS_IDX        = 16'hFF50;
  localparam logic [IDX_W-1:0] EVENT_MASK_IDX          = 16'hFF51;

  // ==========================================================================
  // Field positions
  localparam int RUN_BIT    = 0;
  localparam int CLR_BIT    = 1;
  localparam int TAP_1HZ    = 7;
  localparam int TAP_2HZ    = 6;
  localparam int TAP_8HZ    = 4;
  localparam int TAP_32HZ   = 2;
  localparam int EV_TICK    = 0;
  localparam int EV_HALT    = 1;
  localparam int LEVEL_W    = 2;
  localparam int FACTORS    = 4;
  localparam int EVENTS     = 2;
  localparam int COUNT_W    = 8;

  // ==========================================================================
  // Reset values and steps
  localparam logic [COUNT_W-1:0] COUNT_RST  = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;
  localparam logic [LEVEL_W-1:0] LEVEL_RST  = 2'h0;
  localparam logic [FACTORS-1:0] FACTOR_RST = 4'h0;
  localparam logic [EVENTS-1:0]  EVENT_RST  = 2'h0;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 32'h0000_0000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic               req;
    logic [LEVEL_W-1:0] level;
  } cpu_irq_s;

  typedef struct packed {
    logic               waitreq;
    logic [DATA_W-1:0]  rdata;
    logic [COUNT_W-1:0] count;
    logic               run_req;
    logic               run_act;
    logic               tick_prev;
    logic [LEVEL_W-1:0] prio;
    logic [FACTORS-1:0] en;
    logic [FACTORS-1:0] flag;
    logic [EVENTS-1:0]  ev_sts;
    logic [EVENTS-1:0]  ev_msk;
    logic               ev_irq;
    cpu_irq_s           cpu;
  } state_s;

  localparam state_s STATE_RST = '{
    waitreq:   1'b1,
    rdata:     DATA_ZERO,
    count:     COUNT_RST,
    run_req:   1'b0,
    run_act:   1'b0,
    tick_prev: 1'b0,
    prio:      LEVEL_RST,
    en:        FACTOR_RST,
    flag:      FACTOR_RST,
    ev_sts:    EVENT_RST,
    ev_msk:    EVENT_RST,
    ev_irq:    1'b0,
    cpu:       '{req: 1'b0, level: LEVEL_RST}
  };

endpackage

`default_nettype wire

// >>> tick_timer.sv
// Purpose: Eight-bit clock tick timer with factor flags, CPU request and Avalon-MM slave.
// Assumes: The 256 Hz tick arrives synchronous to core_clk_i; one clock domain.
// Notes:   Every bus access answers with waitrequest low in the second cycle.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module tick_timer (
  // Clock and reset
  input  wire logic                                 core_clk_i,
  input  wire logic                                 rst_n_i,
  // Avalon-MM slave
  input  wire logic [tick_timer_pkg::ADDR_W-1:0]    avs_address_i,
  input  wire logic                                 avs_read_i,
  input  wire logic                                 avs_write_i,
  input  wire logic [3:0]                           avs_byteenable_i,
  input  wire logic [tick_timer_pkg::DATA_W-1:0]    avs_writedata_i,
  output logic      [tick_timer_pkg::DATA_W-1:0]    avs_readdata_o,
  output logic                                      avs_waitrequest_o,
  // Time base and CPU side
  input  wire logic                                 tick_256hz_i,
  input  wire logic [tick_timer_pkg::LEVEL_W-1:0]   cpu_mask_level_i,
  output logic                                      cpu_irq_req_o,
  output logic      [tick_timer_pkg::LEVEL_W-1:0]   cpu_irq_level_o,
  // Event interrupt
  output logic                                      irq_o
);

  // ==========================================================================
  // State
  tick_timer_pkg::state_s state_reg;
  tick_timer_pkg::state_s state_next;

  logic                                  tick_fall;
  logic                                  wr_commit;
  logic                                  rd_take;
  logic                                  clr_cmd;
  logic                                  step;
  logic [tick_timer_pkg::IDX_W-1:0]      idx;
  logic [tick_timer_pkg::COUNT_W-1:0]    cnt_inc;
  logic [tick_timer_pkg::COUNT_W-1:0]    bit_falls;
  logic [tick_timer_pkg::FACTORS-1:0]    tap_fall;
  logic [tick_timer_pkg::FACTORS-1:0]    flag_clr;
  logic [tick_timer_pkg::EVENTS-1:0]     ev_set;
  logic [tick_timer_pkg::EVENTS-1:0]     ev_clr;
  logic [tick_timer_pkg::DATA_W-1:0]     rd_mux;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    idx        = avs_address_i[tick_timer_pkg::ADDR_W-1:tick_timer_pkg::IDX_LO];
    // A write lands only at the edge where the master sees waitrequest low
    wr_commit  = avs_write_i & ~state_reg.waitreq & avs_byteenable_i[0];
    rd_take    = (avs_read_i | avs_write_i) & state_reg.waitreq;
    tick_fall  = state_reg.tick_prev & ~tick_256hz_i;
    state_next.tick_prev = tick_256hz_i;

    clr_cmd = wr_commit && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX)
              && avs_writedata_i[tick_timer_pkg::CLR_BIT];
    step    = tick_fall & state_reg.run_act & ~clr_cmd;
    cnt_inc = state_reg.count + tick_timer_pkg::COUNT_STEP;

    // Clear beats the increment; the run state decides whether counting goes on
    if (clr_cmd) begin
      state_next.count = tick_timer_pkg::COUNT_RST;
    end else if (step) begin
      state_next.count = cnt_inc;
    end

    // Requested run state is adopted only on a tick falling edge
    if (tick_fall) begin
      state_next.run_act = state_reg.run_req;
    end
    if (wr_commit && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX)) begin
      state_next.run_req = avs_writedata_i[tick_timer_pkg::RUN_BIT];
    end

    // Tap falling edges come only from the counter stepping, not from a clear
    bit_falls = step ? (state_reg.count & ~cnt_inc) : tick_timer_pkg::COUNT_RST;
    tap_fall  = {bit_falls[tick_timer_pkg::TAP_32HZ], bit_falls[tick_timer_pkg::TAP_8HZ],
                 bit_falls[tick_timer_pkg::TAP_2HZ], bit_falls[tick_timer_pkg::TAP_1HZ]};

    flag_clr = tick_timer_pkg::FACTOR_RST;
    if (wr_commit && (idx == tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX)) begin
      flag_clr = avs_writedata_i[tick_timer_pkg::FACTORS-1:0];
    end
    // Set wins over clear so an edge in the clearing cycle is not lost
    state_next.flag = (state_reg.flag & ~flag_clr) | tap_fall;

    if (wr_commit && (idx == tick_timer_pkg::IRQ_PRIORITY_LEVELS_IDX)) begin
      state_next.prio = avs_writedata_i[tick_timer_pkg::LEVEL_W-1:0];
    end
    if (wr_commit && (idx == tick_timer_pkg::IRQ_ENABLE_BITS_IDX)) begin
      state_next.en = avs_writedata_i[tick_timer_pkg::FACTORS-1:0];
    end

    // CPU request: pending enabled factor at a level above the CPU mask
    state_next.cpu.req   = (|(state_reg.flag & state_reg.en))
                           && (state_reg.prio > cpu_mask_level_i);
    state_next.cpu.level = state_reg.prio;

    // Event status: any tap edge, and the counter actually halting
    ev_set = '0;
    ev_set[tick_timer_pkg::EV_TICK] = |tap_fall;
    ev_set[tick_timer_pkg::EV_HALT] = tick_fall & state_reg.run_act & ~state_reg.run_req;
    ev_clr = '0;
    if (wr_commit && (idx == tick_timer_pkg::EVENT_STATUS_IDX)) begin
      ev_clr = avs_writedata_i[tick_timer_pkg::EVENTS-1:0];
    end
    state_next.ev_sts = (state_reg.ev_sts & ~ev_clr) | ev_set;
    if (wr_commit && (idx == tick_timer_pkg::EVENT_MASK_IDX)) begin
      state_next.ev_msk = avs_writedata_i[tick_timer_pkg::EVENTS-1:0];
    end
    state_next.ev_irq = |(state_reg.ev_sts & state_reg.ev_msk);

    // Read mux; unmapped addresses and reserved bits read as zero
    rd_mux = tick_timer_pkg::DATA_ZERO;
    case (idx)
      tick_timer_pkg::IRQ_PRIORITY_LEVELS_IDX: begin
        rd_mux[tick_timer_pkg::LEVEL_W-1:0] = state_reg.prio;
      end
      tick_timer_pkg::IRQ_ENABLE_BITS_IDX: begin
        rd_mux[tick_timer_pkg::FACTORS-1:0] = state_reg.en;
      end
      tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX: begin
        rd_mux[tick_timer_pkg::FACTORS-1:0] = state_reg.flag;
      end
      tick_timer_pkg::TICK_TIMER_CONTROL_IDX: begin
        // Shows one from the write of one, and until the halt really happens
        rd_mux[tick_timer_pkg::RUN_BIT] = state_reg.run_req | state_reg.run_act;
      end
      tick_timer_pkg::TICK_TIMER_COUNT_IDX: begin
        rd_mux[tick_timer_pkg::COUNT_W-1:0] = state_reg.count;
      end
      tick_timer_pkg::EVENT_STATUS_IDX: begin
        rd_mux[tick_timer_pkg::EVENTS-1:0] = state_reg.ev_sts;
      end
      tick_timer_pkg::EVENT_MASK_IDX: begin
        rd_mux[tick_timer_pkg::EVENTS-1:0] = state_reg.ev_msk;
      end
      default: begin
        rd_mux = tick_timer_pkg::DATA_ZERO;
      end
    endcase

    // One cycle of wait, then one cycle with waitrequest low and data standing
    if (rd_take) begin
      state_next.waitreq = 1'b0;
      state_next.rdata   = rd_mux;
    end else begin
      state_next.waitreq = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= tick_timer_pkg::STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata_o    = state_reg.rdata;
  assign avs_waitrequest_o = state_reg.waitreq;
  assign cpu_irq_req_o     = state_reg.cpu.req;
  assign cpu_irq_level_o   = state_reg.cpu.level;
  assign irq_o             = state_reg.ev_irq;

  // ==========================================================================
  // Checks
  default clocking chk_cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ctrl_clear_s;
    wr_commit && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX)
      && avs_writedata_i[tick_timer_pkg::CLR_BIT];
  endsequence

  sequence stop_written_s;
    wr_commit && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX)
      && !avs_writedata_i[tick_timer_pkg::RUN_BIT] && state_reg.run_act && !tick_fall;
  endsequence

  count_clear_a: assert property (ctrl_clear_s |=> (state_reg.count == 8'h00))
    else $error("count not zero after clear");

  count_step_a: assert property (
    (tick_fall && state_reg.run_act && !clr_cmd)
      |=> (state_reg.count == $past(state_reg.count) + 8'h01))
    else $error("count did not step on tick fall");

  count_held_a: assert property (
    (!state_reg.run_act && !clr_cmd) |=> $stable(state_reg.count))
    else $error("stopped count moved");

  count_ro_a: assert property (
    (wr_commit && (idx == tick_timer_pkg::TICK_TIMER_COUNT_IDX) && !tick_fall)
      |=> $stable(state_reg.count))
    else $error("write changed the count");

  run_sync_a: assert property (
    (state_reg.run_act != $past(state_reg.run_act)) |-> $past(tick_fall))
    else $error("run changed off a tick edge");

  run_readback_a: assert property (
    stop_written_s ##[1:8] (rd_take && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX)
      && state_reg.run_act)
      |=> avs_readdata_o[tick_timer_pkg::RUN_BIT])
    else $error("run read zero before halting");

  clear_reads_zero_a: assert property (
    (rd_take && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX))
      |=> !avs_readdata_o[tick_timer_pkg::CLR_BIT] && !avs_waitrequest_o)
    else $error("clear bit read as one");

  flag_1hz_a: assert property (
    (step && state_reg.count == 8'hFF) |=> state_reg.flag[0])
    else $error("1 Hz flag not set on wrap");

  flag_hold_a: assert property (
    (state_reg.flag[1] && !(wr_commit && (idx == tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX)))
      |=> state_reg.flag[1])
    else $error("2 Hz flag dropped without clear");

  cpu_req_a: assert property (
    ((|(state_reg.flag & state_reg.en)) && (state_reg.prio > cpu_mask_level_i))
      |=> cpu_irq_req_o)
    else $error("CPU request missing");

  cpu_noreq_a: assert property (
    (state_reg.prio <= cpu_mask_level_i) |=> !cpu_irq_req_o)
    else $error("CPU request at masked level");

  bus_answer_a: assert property (
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");

  // ==========================================================================
  // Run control, clearing, factor flag, register access, bus and request checks
  sequence halt_edge_s;
    tick_fall && state_reg.run_act && !state_reg.run_req && !clr_cmd;
  endsequence

  sequence level_written_s;
    wr_commit && (idx == tick_timer_pkg::IRQ_PRIORITY_LEVELS_IDX);
  endsequence

  run_start_a: assert property (
    (tick_fall && state_reg.run_req && !state_reg.run_act) |=> state_reg.run_act)
    else $error("run did not start on tick fall");

  // A stop request still lets one more increment through
  halt_step_a: assert property (
    halt_edge_s |=> (state_reg.count == $past(state_reg.count) + 8'h01)
      && !state_reg.run_act)
    else $error("stop did not step once then halt");

  halt_event_a: assert property (halt_edge_s |=> state_reg.ev_sts[tick_timer_pkg::EV_HALT])
    else $error("halt event not recorded");

  count_wrap_a: assert property (
    (step && state_reg.count == 8'hFF) |=> (state_reg.count == 8'h00))
    else $error("count did not wrap to zero");

  clear_running_a: assert property (
    (clr_cmd && avs_writedata_i[tick_timer_pkg::RUN_BIT] && state_reg.run_act
      && state_reg.run_req) |=> (state_reg.count == 8'h00) && state_reg.run_act)
    else $error("clear while running stopped the timer");

  clear_stopped_a: assert property (
    (clr_cmd && !state_reg.run_act && !state_reg.run_req
      && !avs_writedata_i[tick_timer_pkg::RUN_BIT])
      |=> (state_reg.count == 8'h00) ##1 (state_reg.count == 8'h00))
    else $error("clear while stopped did not hold zero");

  flag_2hz_a: assert property (
    (step && state_reg.count[6:0] == 7'h7F) |=> state_reg.flag[1])
    else $error("2 Hz flag not set on tap fall");

  flag_8hz_a: assert property (
    (step && state_reg.count[4:0] == 5'h1F) |=> state_reg.flag[2])
    else $error("8 Hz flag not set on tap fall");

  flag_32hz_a: assert property (
    (step && state_reg.count[2:0] == 3'h7) |=> state_reg.flag[3])
    else $error("32 Hz flag not set on tap fall");

  // Flags rise only from the counter stepping, never from a clear or a write
  flag_no_spur_a: assert property (
    !step |=> ((state_reg.flag & ~$past(state_reg.flag)) == 4'h0))
    else $error("flag rose without a tap fall");

  flag_clear_a: assert property (
    (wr_commit && (idx == tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX) && avs_writedata_i[3]
      && !(step && state_reg.count[2:0] == 3'h7)) |=> !state_reg.flag[3])
    else $error("32 Hz flag not cleared by a one");

  flag_keep_a: assert property (
    (wr_commit && (idx == tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX) && !avs_writedata_i[0]
      && state_reg.flag[0]) |=> state_reg.flag[0])
    else $error("writing zero cleared the 1 Hz flag");

  prio_write_a: assert property (
    level_written_s |=> (state_reg.prio == $past(avs_writedata_i[1:0]))
      ##1 (cpu_irq_level_o == $past(avs_writedata_i[1:0], 2)))
    else $error("priority write not applied");

  en_write_a: assert property (
    (wr_commit && (idx == tick_timer_pkg::IRQ_ENABLE_BITS_IDX))
      |=> (state_reg.en == $past(avs_writedata_i[3:0])))
    else $error("enable write not applied");

  run_read_a: assert property (
    (rd_take && (idx == tick_timer_pkg::TICK_TIMER_CONTROL_IDX) && state_reg.run_req)
      |=> avs_readdata_o[tick_timer_pkg::RUN_BIT])
    else $error("run bit read zero while requested");

  count_read_a: assert property (
    (rd_take && (idx == tick_timer_pkg::TICK_TIMER_COUNT_IDX))
      |=> (avs_readdata_o == {24'h000000, $past(state_reg.count)}))
    else $error("count read back wrong");

  write_answer_a: assert property (
    (avs_write_i && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("write answer not one cycle");

  // Read data must stand until the next request is taken
  rdata_hold_a: assert property (!rd_take |=> $stable(avs_readdata_o))
    else $error("read data changed between requests");

  idle_wait_a: assert property (
    (!avs_read_i && !avs_write_i && avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest dropped with no request");

  irq_level_a: assert property (
    (|(state_reg.ev_sts & state_reg.ev_msk)) |=> irq_o)
    else $error("event interrupt missing");

  flag_reserved_a: assert property (
    (rd_take && (idx == tick_timer_pkg::IRQ_FACTOR_FLAGS_IDX))
      |=> (avs_readdata_o[tick_timer_pkg::DATA_W-1:tick_timer_pkg::FACTORS] == '0))
    else $error("reserved flag bits read as one");

  en_read_a: assert property (
    (rd_take && (idx == tick_timer_pkg::IRQ_ENABLE_BITS_IDX))
      |=> (avs_readdata_o[3:0] == $past(state_reg.en)))
    else $error("enable bits read back wrong");

  prio_read_a: assert property (
    (rd_take && (idx == tick_timer_pkg::IRQ_PRIORITY_LEVELS_IDX))
      |=> (avs_readdata_o[1:0] == $past(state_reg.prio)))
    else $error("priority read back wrong");

  // No pending enabled factor means no request, however high the level
  req_idle_a: assert property (
    ((state_reg.prio > cpu_mask_level_i) && !(|(state_reg.flag & state_reg.en)))
      |=> !cpu_irq_req_o)
    else $error("CPU request with nothing pending");

endmodule

`default_nettype wire

// >>> cpu_side_model.sv
// Purpose: CPU side and 256 Hz time base facing the tick timer.
// Assumes: Tick period shortened to 2*HALF core clocks.
// Notes:   Acceptance lifts the mask to the granted level until ret_i.
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model #(
  parameter int HALF = 8
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Timer side
  input  wire logic       irq_req_i,
  input  wire logic [1:0] irq_level_i,
  output logic            tick_256hz_o,
  output logic [1:0]      mask_level_o,
  // Bench side
  input  wire logic [1:0] base_mask_i,
  input  wire logic       ret_i,
  output var int          accepted_o
);
  int         ph = 0;
  logic       tick_q = 1'h0;
  logic [1:0] mask_q = 2'h0;
  assign tick_256hz_o = tick_q;
  assign mask_level_o = mask_q;
  initial accepted_o = 0;
  // ==========
  // Time base runs free, the oscillator never stops
  always @(posedge core_clk_i) begin
    ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
    tick_q <= (ph < HALF);
  end
  // ==========
  // A return drops the mask so a pending factor can be taken again
  always @(posedge core_clk_i) begin
    if (!rst_n_i || ret_i) begin
      mask_q <= base_mask_i;
    end else if (irq_req_i && irq_level_i > mask_q) begin
      mask_q <= irq_level_i;
      accepted_o <= accepted_o + 1;
    end
  end
endmodule
`default_nettype wire

// >>> clock_timer_control_tb_top.sv
// Purpose: Self-checking bench for the tick timer against a shadow model.
// Assumes: Tick period of 16 core clocks from the partner.
// Notes:   Request and interrupt outputs compared every cycle, read data at every read answer.
`timescale 1ns/1ps
`default_nettype none
module clock_timer_control_tb_top;
  localparam logic [15:0] PRI = 16'hFF20, ENA = 16'hFF22, FLG = 16'hFF26, CTL = 16'hFF40;
  localparam logic [15:0] CNT = 16'hFF41, STS = 16'hFF50, MSK = 16'hFF51;
  localparam logic [15:0] ALL [8] = '{PRI, ENA, FLG, CTL, CNT, STS, MSK, 16'hFF30};
  localparam int TAPS [4] = '{7, 6, 4, 2};
  logic        clk = 1'h0, rst_n = 1'h0, rd_en = 1'h0, wr_en = 1'h0, ret = 1'h0;
  logic [17:0] addr = 18'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        waitreq, irq_req, irq, tick;
  logic [1:0]  irq_lvl, mask_lvl, base_mask = 2'h0;
  int          accepted, n_fail = 0, comparisons = 0, i;
  int          cnt, pri, en, flg, sts, msk, exp_rd;
  bit          run_rq, run_act, tprev, e_req, e_irq;

  initial forever #20 clk = ~clk;

  tick_timer tick_timer_i (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .tick_256hz_i(tick),
    .cpu_mask_level_i(mask_lvl), .cpu_irq_req_o(irq_req), .cpu_irq_level_o(irq_lvl),
    .irq_o(irq));
  cpu_side_model cpu_side_model_i (.core_clk_i(clk), .rst_n_i(rst_n), .irq_req_i(irq_req),
    .irq_level_i(irq_lvl), .tick_256hz_o(tick), .mask_level_o(mask_lvl),
    .base_mask_i(base_mask), .ret_i(ret), .accepted_o(accepted));

  // ==========
  // Compare and report
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========
  // Shadow model; read value is snapshot at the capture edge
  function automatic int regval(input logic [15:0] idx);
    case (idx)
      PRI: return pri;
      ENA: return en;
      FLG: return flg;
      CTL: return int'(run_rq | run_act);
      CNT: return cnt;
      STS: return sts;
      MSK: return msk;
      default: return 0;
    endcase
  endfunction
  always @(posedge clk) begin
    logic [7:0] nc, d;
    bit w, fall, rq_old;
    if (!rst_n) begin
      {cnt, pri, en, flg, sts, msk} = '0;
      {run_rq, run_act, tprev, e_req, e_irq} = '0;
    end else begin
      chk_bit(irq_req, e_req);
      chk_bit(irq, e_irq);
      e_req = ((flg & en) != 0) && (pri > int'(mask_lvl));
      e_irq = (sts & msk) != 0;
      if (rd_en && waitreq) exp_rd = regval(addr[17:2]);
      w = wr_en && !waitreq && be[0];
      d = wdata[7:0];
      rq_old = run_rq;
      fall = tprev && !tick;
      tprev = tick;
      if (w) begin
        case (addr[17:2])
          PRI: pri = d[1:0];
          ENA: en = d[3:0];
          FLG: flg = flg & ~d[3:0];
          CTL: run_rq = d[0];
          STS: sts = sts & ~d[1:0];
          MSK: msk = d[1:0];
          default: ;
        endcase
      end
      if (fall && run_act && !(w && addr[17:2] == CTL && d[1])) begin
        nc = cnt[7:0] + 8'h01;
        for (int b = 0; b < 4; b++) begin
          if (cnt[TAPS[b]] && !nc[TAPS[b]]) begin
            flg[b] = 1'h1;
            sts[0] = 1'h1;
          end
        end
        cnt = nc;
      end
      if (fall) begin
        if (run_act && !rq_old) sts[1] = 1'h1;
        run_act = rq_old;
      end
      if (w && addr[17:2] == CTL && d[1]) cnt = 0;
    end
  end

  // ==========
  // Avalon master: hold until waitrequest sampled low
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    addr <= {idx, 2'h0};
    rd_en <= ~wr;
    wr_en <= wr;
    be <= b;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'h0 && n < 50);
    if (n >= 50) chk_bit(1'h0, 1'h1);
    if (!wr) chk_word(rdata, exp_rd);
    if (!wr && idx == PRI) chk_word({30'h0, irq_lvl}, pri);
    rd_en <= 1'h0;
    wr_en <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] idx);
    bus(idx, 1'h0, 8'h00, 4'hF);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(idx, 1'h1, d, 4'hF);
  endtask
  task automatic cpu_ret(input logic [1:0] m);
    base_mask <= m;
    ret <= 1'h1;
    @(posedge clk);
    ret <= 1'h0;
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h91C0));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (ALL[k]) rd(ALL[k]);
    wr(CNT, 8'hA5);
    bus(PRI, 1'h1, 8'h03, 4'h0);
    rd(CNT);
    rd(PRI);
    for (i = 0; i < 4; i++) begin
      cpu_ret(2'($urandom_range(0, 3)));
      wr(PRI, {6'($urandom), 2'(i)});
      rd(PRI);
    end
    wr(MSK, 8'h03);
    wr(CTL, 8'h01);
    for (i = 0; i < 25; i++) begin
      repeat ($urandom_range(1, 30)) @(posedge clk);
      rd(CNT);
    end
    rd(FLG);
    wr(CTL, 8'h03);
    rd(CTL);
    rd(CNT);
    wr(CTL, 8'h00);
    rd(CTL);
    repeat (40) @(posedge clk);
    rd(CTL);
    rd(CNT);
    wr(CTL, 8'h02);
    repeat (40) @(posedge clk);
    rd(CNT);
    rd(STS);
    wr(STS, 8'h03);
    wr(FLG, 8'h0F);
    rd(FLG);
    wr(ENA, 8'($urandom));
    rd(ENA);
    wr(ENA, 8'h0F);
    wr(PRI, 8'h03);
    cpu_ret(2'h1);
    wr(CTL, 8'h01);
    for (i = 0; i < 30; i++) begin
      repeat (160) @(posedge clk);
      rd(FLG);
      if (i % 5 == 4) begin
        wr(FLG, 8'($urandom));
        cpu_ret(2'($urandom));
        wr(MSK, 8'($urandom));
      end
    end
    chk_bit(accepted > 0, 1'h1);
    wr(CTL, 8'h00);
    repeat (40) @(posedge clk);
    rd(CTL);
    rd(STS);
    final_report;
  end

  // Cut a hang short well past the expected run length
  initial begin
    #800000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
